// ---- design/analog_misc_map.svh ----
// register offsets, field positions and reset values of the analog support register bank
`ifndef ANALOG_MISC_MAP_SVH
`define ANALOG_MISC_MAP_SVH

// ***********************************************************
// register byte offsets
// ***********************************************************
`define CLK_CFG_ADDR   12'h02a
`define POS_ADDR_B0    12'h02c
`define POS_ADDR_B1    12'h02d
`define POS_ADDR_B2    12'h02e
`define FS_A_ADDR_LO   12'h030
`define FS_A_ADDR_HI   12'h031
`define FS_B_ADDR_LO   12'h032
`define FS_B_ADDR_HI   12'h033
`define REF_BYP_ADDR   12'h038
`define TS_CFG_ADDR    12'h03b

// ***********************************************************
// field positions
// ***********************************************************
`define CLK_PECL_BIT     2
`define STB_PECL_BIT     1
`define STB_INV_BIT      0
`define REF_BYP_BIT      0
`define TS_PECL_BIT      1
`define TS_EN_BIT        0

// ***********************************************************
// reset values and the recommended full-scale minimum
// ***********************************************************
`define CLK_CFG_RST    8'h00
`define POS_RST        24'h000000
`define FS_RST         16'ha000
`define FS_MIN_REC     16'h2000
`define REF_BYP_RST    8'h00
`define TS_CFG_RST     8'h00
`define RDATA_RST      8'h00

`endif

// ---- design/analog_misc_pkg.sv ----
// types shared by the analog support register bank
package analog_misc_pkg;

  // settings driven into the analog front end
  typedef struct packed {
    logic        clk_rx_lowv_pecl_sel;
    logic        strobe_rx_lowv_pecl_sel;
    logic        strobe_polarity_invert;
    logic [15:0] input_a_fullscale;
    logic [15:0] input_b_fullscale;
    logic        reference_bypass;
    logic        timestamp_rx_lowv_pecl_sel;
    logic        timestamp_rx_enable;
  } analog_cfg_s;

  // byte access from the serial control port decoder
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

endpackage : analog_misc_pkg

// ---- design/analog_misc_config_regs.sv ----
// analog support configuration and status register bank behind the serial control port
//
// Contract
// (RULE_01) bit 2 of clock_input_config selects low-voltage PECL for the sampling clock receiver.
// (RULE_02) bit 1 of clock_input_config selects low-voltage PECL for the strobe receiver.
// (RULE_03) bit 0 of clock_input_config inverts the strobe before alignment use.
// (RULE_04) read-only 24-bit strobe edge position relative to the sampling clock.
// (RULE_05) software reads the edge position to pick the strobe delay select.
// (RULE_06) 16-bit input A full-scale code, reset 0xa000, applied to input A.
// (RULE_07) separate input B full-scale code, same encoding, reset 0xa000.
// (RULE_08) software should not program full-scale codes below 0x2000.
// (RULE_09) bit 0 of reference_bypass selects the 1.1 V supply as reference.
// (RULE_10) bit 1 of timestamp_input_config selects low-voltage PECL for the timestamp receiver.
// (RULE_11) timestamp input enabled only while bit 0 of timestamp_input_config is set.
// (RULE_12) software picks the 4-bit delay select; zero selects automatic calibration.
// (RULE_13) read/write fields, reserved bits included, read back exactly as written.
`timescale 1ns/100ps
`include "analog_misc_map.svh"

module analog_misc_config_regs #(
  parameter int ADDR_W = 12,
  parameter int FS_W   = 16,
  parameter int POS_W  = 24
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire analog_misc_pkg::reg_req_s reg_req,
  output logic [7:0]                     reg_rdata,
  output logic                           reg_rvalid,
  input  wire logic                      pos_capture_valid,
  input  wire logic [POS_W-1:0]          pos_capture_value,
  input  wire logic                      strobe_in,
  output logic                           strobe_aligned,
  input  wire logic                      timestamp_in,
  output logic                           timestamp_gated,
  output analog_misc_pkg::analog_cfg_s   analog_cfg
);

  // ***********************************************************
  // elaboration checks
  // ***********************************************************
  if (ADDR_W != 12 || FS_W != 16 || POS_W != 24) begin : g_bad_param
    $error("analog_misc_config_regs: widths must be 12, 16 and 24");
  end

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [15:0] put_byte(input logic [15:0] word,
                                           input logic        hi,
                                           input logic [7:0]  b);
    put_byte = hi ? {b, word[7:0]} : {word[15:8], b};
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [7:0]       clk_cfg_q;
  logic [POS_W-1:0] pos_q;
  logic [FS_W-1:0]  fs_a_q;
  logic [FS_W-1:0]  fs_b_q;
  logic [7:0]       ref_byp_q;
  logic [7:0]       ts_cfg_q;
  logic [7:0]       rd_mux;
  logic             wr;
  logic [11:0]      wa;

  assign wr = reg_req.wr;
  assign wa = reg_req.addr;

  // whole byte kept so reserved bits read back as written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_cfg_q <= `CLK_CFG_RST;
    end else if (wr && hit(wa, `CLK_CFG_ADDR)) begin
      clk_cfg_q <= reg_req.wdata; // RULE_13
    end
  end

  // low byte at the lower offset; codes under the recommended minimum are still taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_a_q <= `FS_RST; // RULE_06
    end else if (wr && (hit(wa, `FS_A_ADDR_LO) || hit(wa, `FS_A_ADDR_HI))) begin
      fs_a_q <= put_byte(fs_a_q, hit(wa, `FS_A_ADDR_HI), reg_req.wdata); // RULE_06
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fs_b_q <= `FS_RST; // RULE_07
    end else if (wr && (hit(wa, `FS_B_ADDR_LO) || hit(wa, `FS_B_ADDR_HI))) begin
      fs_b_q <= put_byte(fs_b_q, hit(wa, `FS_B_ADDR_HI), reg_req.wdata); // RULE_07
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_byp_q <= `REF_BYP_RST;
    end else if (wr && hit(wa, `REF_BYP_ADDR)) begin
      ref_byp_q <= reg_req.wdata; // RULE_13
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_cfg_q <= `TS_CFG_RST; // RULE_11
    end else if (wr && hit(wa, `TS_CFG_ADDR)) begin
      ts_cfg_q <= reg_req.wdata; // RULE_13
    end
  end

  // position is status only: writes are ignored, capture strobe loads it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_q <= `POS_RST;
    end else if (pos_capture_valid) begin
      pos_q <= pos_capture_value; // RULE_04
    end
  end

  // ***********************************************************
  // read path
  // ***********************************************************
  always_comb begin
    rd_mux = `RDATA_RST;
    case (reg_req.addr)
      `CLK_CFG_ADDR: rd_mux = clk_cfg_q;
      `POS_ADDR_B0:  rd_mux = pos_q[7:0]; // RULE_04
      `POS_ADDR_B1:  rd_mux = pos_q[15:8];
      `POS_ADDR_B2:  rd_mux = pos_q[23:16];
      `FS_A_ADDR_LO: rd_mux = fs_a_q[7:0];
      `FS_A_ADDR_HI: rd_mux = fs_a_q[15:8];
      `FS_B_ADDR_LO: rd_mux = fs_b_q[7:0];
      `FS_B_ADDR_HI: rd_mux = fs_b_q[15:8];
      `REF_BYP_ADDR: rd_mux = ref_byp_q;
      `TS_CFG_ADDR:  rd_mux = ts_cfg_q;
      default:       rd_mux = `RDATA_RST;
    endcase
  end

  // read answers one cycle after the request; a same-cycle write is seen later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= `RDATA_RST;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_mux; // RULE_13
      end
    end
  end

  // ***********************************************************
  // analog controls and conditioned inputs
  // ***********************************************************
  always_comb begin
    analog_cfg.clk_rx_lowv_pecl_sel       = clk_cfg_q[`CLK_PECL_BIT]; // RULE_01
    analog_cfg.strobe_rx_lowv_pecl_sel    = clk_cfg_q[`STB_PECL_BIT]; // RULE_02
    analog_cfg.strobe_polarity_invert     = clk_cfg_q[`STB_INV_BIT];  // RULE_03
    analog_cfg.input_a_fullscale          = fs_a_q;                   // RULE_06
    analog_cfg.input_b_fullscale          = fs_b_q;                   // RULE_07
    analog_cfg.reference_bypass           = ref_byp_q[`REF_BYP_BIT];  // RULE_09
    analog_cfg.timestamp_rx_lowv_pecl_sel = ts_cfg_q[`TS_PECL_BIT];   // RULE_10
    analog_cfg.timestamp_rx_enable        = ts_cfg_q[`TS_EN_BIT];     // RULE_11
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_aligned <= 1'b0;
    end else begin
      strobe_aligned <= strobe_in ^ clk_cfg_q[`STB_INV_BIT]; // RULE_03
    end
  end

  // gating keeps a floating receiver from reaching the timestamp logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timestamp_gated <= 1'b0;
    end else begin
      timestamp_gated <= timestamp_in & ts_cfg_q[`TS_EN_BIT]; // RULE_11
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence wr_at(logic [11:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence

  sequence rd_at(logic [11:0] a);
    reg_req.rd && !reg_req.wr && reg_req.addr == a;
  endsequence

  clk_pecl_set_a: assert property (wr_at(`CLK_CFG_ADDR) |=> // RULE_01
    analog_cfg.clk_rx_lowv_pecl_sel == $past(reg_req.wdata[`CLK_PECL_BIT]))
    else $error("sampling clock pecl select does not follow write");

  strobe_pecl_set_a: assert property (wr_at(`CLK_CFG_ADDR) |=> // RULE_02
    analog_cfg.strobe_rx_lowv_pecl_sel == $past(reg_req.wdata[`STB_PECL_BIT]))
    else $error("strobe pecl select does not follow write");

  strobe_invert_path_a: assert property ($past(reg_req.wr) == 1'b0 |-> // RULE_03
    ##1 strobe_aligned == ($past(strobe_in) ^ $past(clk_cfg_q[`STB_INV_BIT], 2)))
    else $error("strobe polarity not applied");

  // capture, then a read of the top position byte on the very next cycle
  sequence cap_then_top_rd;
    pos_capture_valid ##1 (!pos_capture_valid && reg_req.rd && reg_req.addr == `POS_ADDR_B2);
  endsequence

  pos_capture_read_a: assert property (cap_then_top_rd |=> // RULE_04
    reg_rdata == $past(pos_capture_value[23:16], 2))
    else $error("edge position capture not returned");

  fs_a_high_a: assert property (wr_at(`FS_A_ADDR_HI) |=> // RULE_06
    fs_a_q[15:8] == $past(reg_req.wdata) && $stable(fs_a_q[7:0]))
    else $error("input a full-scale high byte wrong");

  fs_b_reset_a: assert property ($past(rst) && !$past(reg_req.wr) |-> // RULE_07
    analog_cfg.input_b_fullscale == `FS_RST)
    else $error("input b full-scale reset value wrong");

  ref_bypass_set_a: assert property (wr_at(`REF_BYP_ADDR) |=> // RULE_09
    analog_cfg.reference_bypass == $past(reg_req.wdata[`REF_BYP_BIT]))
    else $error("reference bypass does not follow write");

  ts_pecl_set_a: assert property (wr_at(`TS_CFG_ADDR) |=> // RULE_10
    analog_cfg.timestamp_rx_lowv_pecl_sel == $past(reg_req.wdata[`TS_PECL_BIT]))
    else $error("timestamp pecl select does not follow write");

  ts_gate_hold_a: assert property (!analog_cfg.timestamp_rx_enable [*2] |-> // RULE_11
    !timestamp_gated)
    else $error("timestamp passed while disabled");

  readback_exact_a: assert property ( // RULE_13
    (wr_at(`TS_CFG_ADDR) ##1 rd_at(`TS_CFG_ADDR)) |=> reg_rvalid
    && reg_rdata == $past(reg_req.wdata, 2))
    else $error("readback differs from written byte");

  strobe_invert_set_a: assert property (wr_at(`CLK_CFG_ADDR) |=> // RULE_03
    analog_cfg.strobe_polarity_invert == $past(reg_req.wdata[`STB_INV_BIT]))
    else $error("strobe invert select does not follow write");

  fs_a_low_a: assert property (wr_at(`FS_A_ADDR_LO) |=> // RULE_06
    fs_a_q[7:0] == $past(reg_req.wdata) && $stable(fs_a_q[15:8]))
    else $error("input a full-scale low byte wrong");

  fs_a_reset_a: assert property ($past(rst) && !$past(reg_req.wr) |-> // RULE_06
    analog_cfg.input_a_fullscale == `FS_RST)
    else $error("input a full-scale reset value wrong");

  fs_b_low_a: assert property (wr_at(`FS_B_ADDR_LO) |=> // RULE_07
    fs_b_q[7:0] == $past(reg_req.wdata) && $stable(fs_b_q[15:8]))
    else $error("input b full-scale low byte wrong");

  fs_b_high_a: assert property (wr_at(`FS_B_ADDR_HI) |=> // RULE_07
    fs_b_q[15:8] == $past(reg_req.wdata) && $stable(fs_b_q[7:0]))
    else $error("input b full-scale high byte wrong");

  ts_enable_set_a: assert property (wr_at(`TS_CFG_ADDR) |=> // RULE_11
    analog_cfg.timestamp_rx_enable == $past(reg_req.wdata[`TS_EN_BIT]))
    else $error("timestamp enable does not follow write");

  ts_gate_pass_a: assert property (analog_cfg.timestamp_rx_enable && timestamp_in |=> // RULE_11
    timestamp_gated)
    else $error("timestamp blocked while enabled");

  pos_capture_load_a: assert property (pos_capture_valid |=> // RULE_04
    pos_q == $past(pos_capture_value))
    else $error("edge position not loaded on capture");

  pos_hold_a: assert property (!pos_capture_valid |=> // RULE_04
    $stable(pos_q))
    else $error("edge position changed without a capture");

  clk_cfg_store_a: assert property (wr_at(`CLK_CFG_ADDR) |=> // RULE_13
    clk_cfg_q == $past(reg_req.wdata))
    else $error("clock config byte not stored whole");

  ref_byp_store_a: assert property (wr_at(`REF_BYP_ADDR) |=> // RULE_13
    ref_byp_q == $past(reg_req.wdata))
    else $error("reference bypass byte not stored whole");

  cfg_hold_a: assert property (!reg_req.wr |=> $stable(clk_cfg_q) // RULE_13
    && $stable(ref_byp_q) && $stable(ts_cfg_q) && $stable(fs_a_q) && $stable(fs_b_q))
    else $error("configuration changed without a write");

  rd_old_value_a: assert property ( // RULE_13
    reg_req.wr && reg_req.rd && reg_req.addr == `REF_BYP_ADDR |=>
    reg_rdata == $past(ref_byp_q))
    else $error("same-cycle read did not return the old byte");

  // read valid stands for exactly the one cycle after the request
  sequence rd_then_idle;
    reg_req.rd ##1 !reg_req.rd;
  endsequence

  rvalid_pulse_a: assert property (rd_then_idle |-> // RULE_13
    reg_rvalid ##1 !reg_rvalid)
    else $error("read valid does not stand exactly one cycle");

endmodule // analog_misc_config_regs

// ---- sim/tb.sv ----
// self-checking bench for the analog support register bank
`timescale 1ns/100ps
`include "analog_misc_map.svh"

module tb;
  logic                         clk = 1'b0;
  logic                         rst = 1'b1;
  analog_misc_pkg::reg_req_s    req = '0;
  logic [7:0]                   rdata;
  logic                         rvalid;
  logic                         cap_v = 1'b0;
  logic [23:0]                  cap_val = 24'h000000;
  logic                         stb_in = 1'b0;
  logic                         stb_out;
  logic                         ts_in = 1'b0;
  logic                         ts_out;
  analog_misc_pkg::analog_cfg_s cfg;
  logic [15:0]                  fs_codes [3] = '{16'h2000, 16'hffff, 16'h1000};
  int                           err_count = 0;
  int                           samples_checked = 0;
  int                           cycles = 0;

  always #2.5 clk = ~clk;

  analog_misc_config_regs #(.ADDR_W(12), .FS_W(16), .POS_W(24)) dut (
    .clk               (clk),
    .rst               (rst),
    .reg_req           (req),
    .reg_rdata         (rdata),
    .reg_rvalid        (rvalid),
    .pos_capture_valid (cap_v),
    .pos_capture_value (cap_val),
    .strobe_in         (stb_in),
    .strobe_aligned    (stb_out),
    .timestamp_in      (ts_in),
    .timestamp_gated   (ts_out),
    .analog_cfg        (cfg)
  );

  // ***********************************************************
  // access tasks
  // ***********************************************************
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr_byte(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    req.addr  = a;
    req.wdata = d;
    req.wr    = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // answer lands on the taking edge itself, so look at the next falling edge
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    req.addr = a;
    req.rd   = 1'b1;
    @(negedge clk);
    req.rd = 1'b0;
    check({31'h0, rvalid, rdata}, {32'h1, exp});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ***********************************************************
  // scenarios
  // ***********************************************************
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check(cfg.input_a_fullscale, 16'ha000);
    check(cfg.input_b_fullscale, 16'ha000);
    check({cfg.reference_bypass, cfg.timestamp_rx_enable}, 2'b00);
    rd_chk(`FS_A_ADDR_HI, 8'ha0);
    rd_chk(`FS_B_ADDR_LO, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr_byte(`CLK_CFG_ADDR, 8'(8'h01 << i));
      check({cfg.clk_rx_lowv_pecl_sel, cfg.strobe_rx_lowv_pecl_sel,
             cfg.strobe_polarity_invert}, 3'(3'b001 << i));
    end
    // reserved bits must survive alongside the invert bit
    wr_byte(`CLK_CFG_ADDR, 8'hf9);
    rd_chk(`CLK_CFG_ADDR, 8'hf9);
    stb_in = 1'b1;
    @(negedge clk);
    check(stb_out, 1'b0);
    wr_byte(`CLK_CFG_ADDR, 8'h00);
    // the aligned strobe lags the invert bit by one cycle
    @(negedge clk);
    check(stb_out, 1'b1);
    foreach (fs_codes[i]) begin
      wr_byte(`FS_A_ADDR_LO, fs_codes[i][7:0]);
      wr_byte(`FS_A_ADDR_HI, fs_codes[i][15:8]);
      wr_byte(`FS_B_ADDR_LO, fs_codes[i][15:8]);
      wr_byte(`FS_B_ADDR_HI, fs_codes[i][7:0]);
      check(cfg.input_a_fullscale, fs_codes[i]);
      check(cfg.input_b_fullscale, {fs_codes[i][7:0], fs_codes[i][15:8]});
      rd_chk(`FS_B_ADDR_HI, fs_codes[i][7:0]);
    end
    wr_byte(`REF_BYP_ADDR, 8'hfe);
    check(cfg.reference_bypass, 1'b0);
    rd_chk(`REF_BYP_ADDR, 8'hfe);
    wr_byte(`REF_BYP_ADDR, 8'h01);
    check(cfg.reference_bypass, 1'b1);
    wr_byte(`TS_CFG_ADDR, 8'h02);
    ts_in = 1'b1;
    @(negedge clk);
    check({cfg.timestamp_rx_lowv_pecl_sel, ts_out}, 2'b10);
    // write, then read back on the very next cycle
    @(negedge clk);
    req.addr  = `TS_CFG_ADDR;
    req.wdata = 8'hfd;
    req.wr    = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b1;
    @(negedge clk);
    req.rd = 1'b0;
    check({cfg.timestamp_rx_lowv_pecl_sel, ts_out}, 2'b01);
    check({rvalid, rdata}, 9'h1fd);
    // capture, then a stale value that must not be taken
    @(negedge clk);
    cap_val = 24'h123456;
    cap_v   = 1'b1;
    @(negedge clk);
    cap_v    = 1'b0;
    cap_val  = 24'hedcba9;
    req.addr = `POS_ADDR_B2;
    req.rd   = 1'b1;
    @(negedge clk);
    req.rd = 1'b0;
    check({rvalid, rdata}, 9'h112);
    wr_byte(`POS_ADDR_B0, 8'haa);
    // delay select lives outside this bank; the bench only fetches what it is picked from
    rd_chk(`POS_ADDR_B0, 8'h56);
    rd_chk(`POS_ADDR_B1, 8'h34);
    rd_chk(`POS_ADDR_B2, 8'h12);
    wr_byte(12'h02b, 8'hff);
    rd_chk(12'h02b, 8'h00);
    // write and read in one cycle: the read sees the old byte
    @(negedge clk);
    req.addr  = `REF_BYP_ADDR;
    req.wdata = 8'h55;
    req.wr    = 1'b1;
    req.rd    = 1'b1;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    check({rvalid, rdata}, 9'h101);
    rd_chk(`REF_BYP_ADDR, 8'h55);
    // second reset in mid-run restores the defaults
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check({cfg.input_a_fullscale, cfg.timestamp_rx_enable}, 17'h14000);
    tally_and_finish();
  end
endmodule // tb
